//--- shared/interval_timer_pkg.sv
// Shared constants for the interval timer channel
package interval_timer_pkg;

    // ********************************************
    // Bus geometry
    // ********************************************
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int REG_W = 16;

    // ********************************************
    // Register byte offsets
    // ********************************************
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_EDGE = 8'h04;
    localparam logic [7:0] ADDR_PERIOD = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0C;
    localparam logic [7:0] ADDR_TRIG = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_OUTCTL = 8'h18;
    localparam logic [7:0] ADDR_PRESC = 8'h1C;

    // ********************************************
    // Field positions
    // ********************************************
    localparam int CKS_LSB = 14;
    localparam int CCS_BIT = 12;
    localparam int STS_LSB = 8;
    localparam int MD_LSB = 1;
    localparam int MD0_BIT = 0;
    localparam int TRIG_START_BIT = 0;
    localparam int TRIG_STOP_BIT = 1;
    localparam int STAT_RUN_BIT = 0;
    localparam int STAT_OUT_BIT = 1;
    localparam int OUT_DIRDIS_BIT = 0;
    localparam int OUT_MODE_BIT = 1;
    localparam int OUT_POL_BIT = 3;
    localparam int OUT_LEVEL_BIT = 10;
    localparam int PRESC_FLD_W = 4;

    // ********************************************
    // Reset values and codes
    // ********************************************
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] EDGE_RST = 16'h0000;
    localparam logic [15:0] PERIOD_RST = 16'h0000;
    localparam logic [15:0] OUTCTL_RST = 16'h0000;
    localparam logic [15:0] PRESC_RST = 16'h3210;
    localparam logic [2:0] STS_EDGE = 3'b001;
    localparam logic [3:0] MD_INTERVAL = 4'b0000;
    localparam logic [1:0] EDGE_FALL = 2'b00;
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_BOTH = 2'b10;

    typedef enum logic [0:0] {
        RUN_STOPPED = 1'b0,
        RUN_ACTIVE = 1'b1
    } run_state_t;

endpackage

//--- rtl/interval_timer_edge_restart.sv
// One interval timer channel with input-edge restart and a Wishbone slave
`timescale 1ns/100ps
`default_nettype none

module interval_timer_edge_restart (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [interval_timer_pkg::ADR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [interval_timer_pkg::DAT_W-1:0] wb_dat_in,
    output logic [interval_timer_pkg::DAT_W-1:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic channel_in_in,
    output logic channel_out_out,
    output logic channel_irq_out
);
    import interval_timer_pkg::*;

    // ********************************************
    // Storage
    // ********************************************
    logic [REG_W-1:0] mode_r;
    logic [REG_W-1:0] edge_r;
    logic [REG_W-1:0] period_r;
    logic [REG_W-1:0] outctl_r;
    logic [REG_W-1:0] presc_r;
    logic [REG_W-1:0] cnt_r;
    logic [REG_W-1:0] cnt_nxt;
    logic [REG_W-1:0] pre_cnt_r;
    run_state_t run_r;
    run_state_t run_nxt;
    logic tog_r;
    logic tog_nxt;
    logic in_s1_r;
    logic in_s2_r;
    logic in_s3_r;

    // ********************************************
    // Wishbone slave
    // ********************************************

    // Request seen while no answer is out; ack follows one edge later
    wire req = wb_cyc_in & wb_stb_in;
    wire take = req & ~wb_ack_out;
    // Writes commit on the edge where the master samples ack
    wire wr_en = req & wb_we_in & wb_ack_out;
    wire wr_mode = wr_en & (wb_adr_in == ADDR_MODE);
    wire wr_edge = wr_en & (wb_adr_in == ADDR_EDGE);
    wire wr_period = wr_en & (wb_adr_in == ADDR_PERIOD);
    wire wr_trig = wr_en & (wb_adr_in == ADDR_TRIG) & wb_sel_in[0];
    wire wr_outctl = wr_en & (wb_adr_in == ADDR_OUTCTL);
    wire wr_presc = wr_en & (wb_adr_in == ADDR_PRESC);

    // Byte-lane merge of a 16-bit register
    function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                               input logic [DAT_W-1:0] dat,
                                               input logic [3:0] sel);
        logic [REG_W-1:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            res[15:8] = dat[15:8];
        end
        return res;
    endfunction

    // Read mux; trigger reads zero, unmapped reads zero
    wire [REG_W-1:0] status_w = {14'h0000, channel_out_out, run_r == RUN_ACTIVE};
    wire [REG_W-1:0] rd16 =
        (wb_adr_in == ADDR_MODE) ? mode_r :
        (wb_adr_in == ADDR_EDGE) ? edge_r :
        (wb_adr_in == ADDR_PERIOD) ? period_r :
        (wb_adr_in == ADDR_COUNT) ? cnt_r :
        (wb_adr_in == ADDR_STATUS) ? status_w :
        (wb_adr_in == ADDR_OUTCTL) ? outctl_r :
        (wb_adr_in == ADDR_PRESC) ? presc_r : 16'h0000;

    // Ack and read data
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= take;
            if (take) begin
                wb_dat_out <= {16'h0000, rd16};
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_r <= MODE_RST;
            edge_r <= EDGE_RST;
            period_r <= PERIOD_RST;
            outctl_r <= OUTCTL_RST;
            presc_r <= PRESC_RST;
        end else begin
            if (wr_mode) begin
                mode_r <= merge(mode_r, wb_dat_in, wb_sel_in);
            end
            if (wr_edge) begin
                edge_r <= merge(edge_r, wb_dat_in, wb_sel_in);
            end
            if (wr_period) begin
                period_r <= merge(period_r, wb_dat_in, wb_sel_in);
            end
            if (wr_outctl) begin
                outctl_r <= merge(outctl_r, wb_dat_in, wb_sel_in);
            end
            if (wr_presc) begin
                presc_r <= merge(presc_r, wb_dat_in, wb_sel_in);
            end
        end
    end

    // ********************************************
    // Field decode
    // ********************************************
    wire [1:0] cks = mode_r[CKS_LSB+:2];
    wire ccs = mode_r[CCS_BIT];
    wire [2:0] sts = mode_r[STS_LSB+:3];
    wire md0 = mode_r[MD0_BIT];
    wire mode_ok = (mode_r[MD_LSB+:4] == MD_INTERVAL);
    wire [1:0] esel = edge_r[1:0];
    wire dir_dis = outctl_r[OUT_DIRDIS_BIT];
    wire toggle_mode = dir_dis & ~outctl_r[OUT_MODE_BIT];
    wire out_pol = outctl_r[OUT_POL_BIT];
    wire out_level = outctl_r[OUT_LEVEL_BIT];

    // ********************************************
    // Prescaler: four operation clocks as enables
    // ********************************************

    // Free divider; each clock k ticks when the low exp_k bits are all ones
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pre_cnt_r <= 16'h0000;
        end else begin
            pre_cnt_r <= pre_cnt_r + 16'h0001;
        end
    end

    logic [3:0] ck_tick;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_ck
            wire [REG_W-1:0] mask = ~(16'hFFFF << presc_r[g*PRESC_FLD_W+:PRESC_FLD_W]);
            // Exponent zero gives a mask of zero, so the tick runs every clock
            assign ck_tick[g] = ((pre_cnt_r & mask) == mask);
        end
    endgenerate

    // ********************************************
    // Input synchroniser and edge detect
    // ********************************************

    // The second and third stages feed the detector; one edge makes one event
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            in_s1_r <= 1'b0;
            in_s2_r <= 1'b0;
            in_s3_r <= 1'b0;
        end else begin
            in_s1_r <= channel_in_in;
            in_s2_r <= in_s1_r;
            in_s3_r <= in_s2_r;
        end
    end

    wire rise = in_s2_r & ~in_s3_r;
    wire fall = ~in_s2_r & in_s3_r;
    wire edge_valid = (esel == EDGE_FALL) ? fall :
                      (esel == EDGE_RISE) ? rise :
                      (esel == EDGE_BOTH) ? (rise | fall) : 1'b0;

    // ********************************************
    // Counter control
    // ********************************************
    wire running = (run_r == RUN_ACTIVE);
    // Count clock: operation clock, or input edges when source select is set
    wire count_src = ccs ? edge_valid : ck_tick[cks];
    wire count_tick = running & mode_ok & count_src;
    wire start_req = wr_trig & wb_dat_in[TRIG_START_BIT];
    wire stop_req = wr_trig & wb_dat_in[TRIG_STOP_BIT];
    // Edge restart only while counting; a stop in the same cycle wins
    wire ext_restart = running & mode_ok & (sts == STS_EDGE) & edge_valid;
    wire restart = (start_req | ext_restart) & ~stop_req;
    wire at_zero = (cnt_r == 16'h0000);
    wire tick_reload = count_tick & at_zero & ~stop_req & ~restart;
    // A restart event follows the start-interrupt select; a reload always fires
    wire event_w = (restart & md0) | tick_reload;

    // Next-state logic for run state, counter and toggle
    always_comb begin
        run_nxt = run_r;
        cnt_nxt = cnt_r;
        tog_nxt = tog_r;
        if (stop_req) begin
            run_nxt = RUN_STOPPED;
        end else if (start_req) begin
            run_nxt = RUN_ACTIVE;
        end
        if (restart) begin
            cnt_nxt = period_r;
        end else if (count_tick & ~stop_req) begin
            cnt_nxt = at_zero ? period_r : cnt_r - 16'h0001;
        end
        if (event_w & toggle_mode) begin
            tog_nxt = ~tog_r;
        end
    end

    // Stopped state holds counter and toggle as they are
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            run_r <= RUN_STOPPED;
            cnt_r <= 16'h0000;
            tog_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
            cnt_r <= cnt_nxt;
            tog_r <= tog_nxt;
        end
    end

    // Outputs registered; direct mode drives the software level
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            channel_irq_out <= 1'b0;
            channel_out_out <= 1'b0;
        end else begin
            channel_irq_out <= event_w;
            channel_out_out <= dir_dis ? (tog_nxt ^ out_pol) : out_level;
        end
    end

    // ********************************************
    // Checks
    // ********************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    property p_zero_stays;
        count_tick && at_zero && period_r == 16'h0000 && !stop_req && !start_req
            && !wr_period |=> cnt_r == 16'h0000;
    endproperty
    a_zero_stays: assert property (p_zero_stays) else $error("zero period left zero");

    property p_reload_irq;
        tick_reload |=> channel_irq_out;
    endproperty
    a_reload_irq: assert property (p_reload_irq) else $error("reload gave no irq");

    property p_full_rate;
        (count_tick && at_zero && period_r == 16'h0000 && !wr_en)[*3]
            |=> channel_irq_out && $past(channel_irq_out, 2);
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("irq not continuous");

    property p_stop;
        stop_req |=> run_r == RUN_STOPPED ##1 $stable(cnt_r);
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not halt");

    property p_freeze;
        !running && !start_req |=> $stable(cnt_r) && $stable(tog_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("stopped state moved");

    property p_start_load;
        start_req && !stop_req |=> running && cnt_r == $past(period_r);
    endproperty
    a_start_load: assert property (p_start_load) else $error("start load wrong");

    property p_md0_on;
        restart && md0 |=> channel_irq_out;
    endproperty
    a_md0_on: assert property (p_md0_on) else $error("restart irq missing");

    property p_md0_off;
        restart && !md0 |=> !channel_irq_out;
    endproperty
    a_md0_off: assert property (p_md0_off) else $error("restart irq unwanted");

    property p_edge_restart;
        ext_restart && !start_req && !stop_req |=> cnt_r == $past(period_r);
    endproperty
    a_edge_restart: assert property (p_edge_restart) else $error("edge no reload");

    property p_toggle;
        event_w && toggle_mode && !wr_en |=> channel_out_out != $past(channel_out_out);
    endproperty
    a_toggle: assert property (p_toggle) else $error("output did not toggle");

    property p_direct;
        !dir_dis |=> channel_out_out == $past(out_level);
    endproperty
    a_direct: assert property (p_direct) else $error("direct level wrong");

    // A detected rise must match a pin change two and three samples back
    property p_one_edge;
        rise && $past(resetn_in, 1) && $past(resetn_in, 2) && $past(resetn_in, 3)
            |-> $past(channel_in_in, 2) && !$past(channel_in_in, 3);
    endproperty
    a_one_edge: assert property (p_one_edge) else $error("edge seen twice");

    c_start: cover property (start_req && md0 ##1 channel_irq_out);
    c_edge: cover property (ext_restart ##1 cnt_r == period_r);
    c_stop: cover property (running ##1 stop_req ##1 !running);
    c_wrap: cover property (tick_reload && period_r != 16'h0000);

endmodule

`default_nettype wire

//--- sim/channel_pin_model.sv
// Behavioural source for the channel input pin
`timescale 1ns/100ps
`default_nettype none

module channel_pin_model (
    input wire logic clk_in,
    input wire logic level_in,
    output logic pin_out
);
    // ********************************************
    // Pin driver
    // ********************************************
    // Registers the wanted level on the clock like a source in the same clock domain
    always @(posedge clk_in) begin
        pin_out <= level_in;
    end
endmodule

`default_nettype wire

//--- sim/testbench.sv
// Self-checking testbench for the interval timer channel
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import interval_timer_pkg::*;

    logic clk_in, resetn_in, cyc, stb, we, ack, pin_lvl, pin, ch_out, irq;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [DAT_W-1:0] wdat, rdat, rd, c1;
    int errors, cmp_count, cyc_n, irq_cnt, n, p, ex, cks;
    int exp_q[$];
    logic o;

    interval_timer_edge_restart dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .channel_in_in(pin),
        .channel_out_out(ch_out), .channel_irq_out(irq));

    channel_pin_model pin_u (.clk_in(clk_in), .level_in(pin_lvl), .pin_out(pin));

    // ********************************************
    // Clock, event counters and watchdog
    // ********************************************
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc_n <= cyc_n + 1;
        if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    end
    // Whole run is far below this span; a hang ends here
    initial begin
        repeat (40000) @(posedge clk_in);
        errors++;
        complete_run();
    end

    // ********************************************
    // Tasks
    // ********************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Classic single cycle; holds everything until ack, the watchdog ends a hang
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'h3;
        do begin
            @(posedge clk_in);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        check(rd, e);
    endtask

    // Model: events every (period + 1) count clocks, count clock = PCLK / 2^exp
    function automatic int gap_of(input int pv, input int ev);
        return (pv + 1) << ev;
    endfunction

    // Gap between two reload events against the queued model gap, and the toggle between
    task automatic measure;
        int t1, k, gap;
        logic o1;
        k = 0;
        gap = exp_q.pop_front();
        do begin
            @(posedge clk_in);
            k++;
        end while (irq !== 1'b1 && k < 2000);
        t1 = cyc_n;
        o1 = ch_out;
        do begin
            @(posedge clk_in);
            k++;
        end while (irq !== 1'b1 && k < 2000);
        check(32'(cyc_n - t1), 32'(gap));
        check({31'd0, ch_out}, {31'd0, ~o1});
    endtask

    task automatic complete_run;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ********************************************
    // Main sequence
    // ********************************************
    initial begin
        {resetn_in, cyc, stb, we, sel, adr, wdat, pin_lvl} = '0;
        {errors, cmp_count, cyc_n, irq_cnt} = '0;
        void'($urandom(31));
        repeat (20) @(posedge clk_in);
        resetn_in <= 1'b1;
        // Reset values, unmapped place reads zero and ignores writes
        rd_chk(ADDR_MODE, 32'(MODE_RST));
        rd_chk(ADDR_EDGE, 32'(EDGE_RST));
        rd_chk(ADDR_PERIOD, 32'(PERIOD_RST));
        rd_chk(ADDR_OUTCTL, 32'(OUTCTL_RST));
        rd_chk(ADDR_PRESC, 32'(PRESC_RST));
        rd_chk(ADDR_STATUS, 32'h0000_0000);
        wb(1'b1, 8'hF0, 32'h0000_FFFF);
        rd_chk(8'hF0, 32'h0000_0000);
        wb(1'b1, ADDR_OUTCTL, 32'h0000_0001);
        // Random clock selection and period, then zero period at PCLK and PCLK/2
        for (int i = 0; i < 6; i++) begin
            cks = $urandom_range(3);
            p = (i < 4) ? $urandom_range(6) : 0;
            ex = (i < 4) ? $urandom_range(2) : i - 4;
            wb(1'b1, ADDR_TRIG, 32'h0000_0002);
            wb(1'b1, ADDR_PRESC, 32'(ex << (4 * cks)));
            wb(1'b1, ADDR_MODE, 32'(cks << CKS_LSB));
            wb(1'b1, ADDR_PERIOD, 32'(p));
            wb(1'b1, ADDR_TRIG, 32'h0000_0001);
            exp_q.push_back(gap_of(p, ex));
            measure();
            if (p == 0) rd_chk(ADDR_COUNT, 32'h0000_0000);
        end
        // Stop freezes counter and output, start reloads with start event
        wb(1'b1, ADDR_PRESC, 32'h0000_0000);
        wb(1'b1, ADDR_PERIOD, 32'h0000_012C);
        wb(1'b1, ADDR_MODE, 32'h0000_0001);
        wb(1'b1, ADDR_TRIG, 32'h0000_0001);
        repeat (50) @(posedge clk_in);
        wb(1'b1, ADDR_TRIG, 32'h0000_0002);
        wb(1'b0, ADDR_STATUS, 32'h0000_0000);
        check({31'd0, rd[STAT_RUN_BIT]}, 32'h0000_0000);
        wb(1'b0, ADDR_COUNT, 32'h0000_0000);
        c1 = rd;
        o = ch_out;
        n = irq_cnt;
        repeat (40) @(posedge clk_in);
        rd_chk(ADDR_COUNT, c1);
        check({31'd0, ch_out}, {31'd0, o});
        check(32'(irq_cnt - n), 32'h0000_0000);
        // Start on stopped channel with start event, then a forced restart without one
        for (int md = 1; md >= 0; md--) begin
            wb(1'b1, ADDR_MODE, 32'(md));
            n = irq_cnt;
            wb(1'b1, ADDR_TRIG, 32'h0000_0001);
            repeat (4) @(posedge clk_in);
            check(32'(irq_cnt - n), 32'(md));
            wb(1'b0, ADDR_COUNT, 32'h0000_0000);
            check({31'd0, rd >= 290 && rd <= 300}, 32'h0000_0001);
            rd_chk(ADDR_TRIG, 32'h0000_0000);
            wb(1'b0, ADDR_STATUS, 32'h0000_0000);
            check({31'd0, rd[STAT_RUN_BIT]}, 32'h0000_0001);
            repeat (150) @(posedge clk_in);
        end
        // Input edges restart the count according to the edge selection; code 11 takes none
        wb(1'b1, ADDR_PERIOD, 32'h0000_03E8);
        wb(1'b1, ADDR_MODE, 32'(32'(STS_EDGE) << STS_LSB) | 32'h0000_0001);
        wb(1'b1, ADDR_TRIG, 32'h0000_0001);
        for (int es = 0; es < 4; es++) begin
            wb(1'b1, ADDR_EDGE, 32'(es));
            for (int lv = 1; lv >= 0; lv--) begin
                repeat (60) @(posedge clk_in);
                n = irq_cnt;
                pin_lvl <= lv[0];
                repeat (8) @(posedge clk_in);
                check(32'(irq_cnt - n), 32'(es == 2 || es == lv));
            end
        end
        // Count source set: valid input edges clock the counter, period one reloads on two
        wb(1'b1, ADDR_EDGE, 32'h0000_0002);
        wb(1'b1, ADDR_PERIOD, 32'h0000_0001);
        wb(1'b1, ADDR_MODE, 32'(1 << CCS_BIT));
        wb(1'b1, ADDR_TRIG, 32'h0000_0001);
        n = irq_cnt;
        for (int t = 0; t < 2; t++) begin
            pin_lvl <= ~pin_lvl;
            repeat (8) @(posedge clk_in);
            check(32'(irq_cnt - n), 32'(t));
        end
        // Direct output level overrides the timer events
        wb(1'b1, ADDR_OUTCTL, 32'h0000_0400);
        repeat (3) @(posedge clk_in);
        check({31'd0, ch_out}, 32'h0000_0001);
        wb(1'b1, ADDR_OUTCTL, 32'h0000_0000);
        repeat (3) @(posedge clk_in);
        check({31'd0, ch_out}, 32'h0000_0000);
        // A mode other than interval does not count
        wb(1'b1, ADDR_MODE, 32'h0000_0002);
        wb(1'b1, ADDR_TRIG, 32'h0000_0001);
        wb(1'b0, ADDR_COUNT, 32'h0000_0000);
        c1 = rd;
        repeat (20) @(posedge clk_in);
        rd_chk(ADDR_COUNT, c1);
        complete_run();
    end
endmodule

`default_nettype wire
